/* File: rtl/rpd_angle_cal.sv */
// monopulse ratio to angle calibration table
`timescale 1ns/10ps
module rpd_angle_cal #(
    parameter int MW = 6,
    parameter int DW = 12
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          cal_we,
    input  wire logic [MW-1:0] cal_idx,
    input  wire logic [DW-1:0] cal_data,
    input  wire logic [MW-1:0] ratio,
    output logic [DW-1:0]      angle_ff
);
    localparam int DEPTH = 1 << MW;
    logic [DW-1:0] tab_ff [DEPTH];

    // table loads from software; resets to zero angle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                tab_ff[i] <= '0;
            end
        end else if (cal_we) begin
            tab_ff[cal_idx] <= cal_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            angle_ff <= '0;
        end else begin
            angle_ff <= tab_ff[ratio];
        end
    end
endmodule // rpd_angle_cal

/* File: rtl/rpd_demod.sv */
// reply preamble detector and pulse-position bit demodulator
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module rpd_demod #(
    parameter int AW       = 8,
    parameter int MW       = 6,
    parameter int DW       = 12,
    parameter int TW       = 24,
    parameter bit EARLY_IS = 1'b1,
    parameter bit TIE_BIT  = 1'b0
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [AW-1:0] log_sum,
    input  wire logic [AW-1:0] log_omni,
    input  wire logic [MW-1:0] mono_ratio,
    input  wire logic [TW-1:0] tod,
    input  wire logic          rc_arm,
    input  wire logic [TW-1:0] rc_expect,
    input  wire logic [TW-1:0] rc_window,
    input  wire logic [3:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic [31:0]        rdata_ff,
    output logic               reply_ff,
    output logic               reply_rc_ff,
    output logic [TW-1:0]      reply_toa_ff,
    output logic [DW-1:0]      reply_az_ff,
    output logic               bit_vld_ff,
    output logic               bit_val_ff,
    output logic               bit_conf_ff,
    output logic               busy
);
    if (AW < 2 || AW > 16 || MW < 1 || MW > 10 || DW > 16 || TW > 32 || TW < 8) begin : g_chk
        $error("rpd_demod: unsupported parameter values");
    end

    // one sample older than the first pulse, to see its leading edge
    localparam int HW = rpd_pkg::PRE_SPAN_CYC + 2;
    localparam int CW = 8;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic          enable_ff;
    logic [AW-1:0] thresh_ff;
    logic [AW-1:0] detect_ff;
    logic [7:0]    nbits_ff;
    logic [15:0]   lost_ff;
    logic [15:0]   accepted_ff;
    logic          cal_we;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enable_ff <= rpd_pkg::CTRL_RST[rpd_pkg::CTRL_EN_BIT];
            thresh_ff <= AW'(rpd_pkg::THRESH_RST);
            detect_ff <= AW'(rpd_pkg::DETECT_RST);
            nbits_ff  <= rpd_pkg::NBITS_RST;
        end else if (wr) begin
            unique case (addr)
                rpd_pkg::REG_CTRL:   enable_ff <= wdata[rpd_pkg::CTRL_EN_BIT];
                rpd_pkg::REG_THRESH: thresh_ff <= wdata[AW-1:0];
                rpd_pkg::REG_NBITS:  nbits_ff  <= (wdata[7:0] == 8'h00) ? 8'h01 : wdata[7:0];
                rpd_pkg::REG_DETECT: detect_ff <= wdata[AW-1:0];
                default: ;
            endcase
        end
    end

    // calibration: index in bits 16 and up, angle in low bits
    assign cal_we = wr && (addr == rpd_pkg::REG_CAL);

    // ------------------------------------------------------------
    // pulse front end
    // ------------------------------------------------------------
    logic          pulse;
    logic          main;
    logic [AW-1:0] amp;
    logic [DW-1:0] angle;

    rpd_pulse_tag #(.AW(AW)) u_tag (
        .clk        (clk),
        .rstn       (rstn),
        .log_sum    (log_sum),
        .log_omni   (log_omni),
        .thresh     (thresh_ff),
        .detect_lvl (detect_ff),
        .pulse_ff   (pulse),
        .main_ff    (main),
        .amp_ff     (amp)
    );

    rpd_angle_cal #(.MW(MW), .DW(DW)) u_cal (
        .clk      (clk),
        .rstn     (rstn),
        .cal_we   (cal_we),
        .cal_idx  (wdata[16 +: MW]),
        .cal_data (wdata[DW-1:0]),
        .ratio    (mono_ratio),
        .angle_ff (angle)
    );

    // ------------------------------------------------------------
    // sample history for preamble match
    // ------------------------------------------------------------
    logic [HW-1:0] hist_ff;
    logic          lead;
    logic          preamble;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hist_ff <= '0;
        end else begin
            hist_ff <= {hist_ff[HW-2:0], pulse};
        end
    end

    // leading edge of the oldest pulse, plus the other three in place
    assign lead = hist_ff[HW-2] && !hist_ff[HW-1];
    assign preamble = hist_ff[HW-2]
                   && hist_ff[HW-2 - rpd_pkg::PRE_P2_CHIP * rpd_pkg::CHIP_CYC]
                   && hist_ff[HW-2 - rpd_pkg::PRE_P3_CHIP * rpd_pkg::CHIP_CYC]
                   && hist_ff[0];

    logic first_edge_ff;
    logic lead_edge;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_edge_ff <= 1'b0;
        end else begin
            first_edge_ff <= preamble;
        end
    end
    // one hit per preamble, at its first matching sample
    assign lead_edge = preamble && !first_edge_ff && lead;

    // ------------------------------------------------------------
    // acceptance window
    // ------------------------------------------------------------
    logic [TW-1:0] toa;
    logic [TW-1:0] diff;
    logic          in_window;
    logic          accept;

    // arrival time of first pulse, span cycles ago
    assign toa  = tod - TW'(rpd_pkg::PRE_SPAN_CYC);
    assign diff = (toa >= rc_expect) ? toa - rc_expect : rc_expect - toa;
    assign in_window = diff <= rc_window;

    rpd_pkg::rpd_state_e state_ff;

    assign accept = enable_ff && lead_edge && (state_ff == rpd_pkg::RPD_IDLE)
                 && (!rc_arm || in_window);
    assign busy   = state_ff != rpd_pkg::RPD_IDLE;

    // ------------------------------------------------------------
    // decode sequencer
    // ------------------------------------------------------------
    logic [CW-1:0] cnt_ff;
    logic [7:0]    bitn_ff;
    logic          bit_end;

    assign bit_end  = cnt_ff == CW'(rpd_pkg::BIT_CYC - 1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= rpd_pkg::RPD_IDLE;
            cnt_ff   <= '0;
            bitn_ff  <= 8'h00;
        end else begin
            unique case (state_ff)
                rpd_pkg::RPD_IDLE: begin
                    cnt_ff  <= '0;
                    bitn_ff <= 8'h00;
                    if (accept) begin
                        state_ff <= rpd_pkg::RPD_WAIT;
                    end
                end
                // bit timing from arrival
                // pulse register and history already lag the line by two samples
                rpd_pkg::RPD_WAIT: begin
                    if (cnt_ff == CW'(rpd_pkg::DATA_OFS_CYC - rpd_pkg::PRE_SPAN_CYC - 3)) begin
                        cnt_ff   <= '0;
                        state_ff <= rpd_pkg::RPD_BITS;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                rpd_pkg::RPD_BITS: begin
                    if (bit_end) begin
                        cnt_ff  <= '0;
                        bitn_ff <= bitn_ff + 8'h01;
                        if (bitn_ff == nbits_ff - 8'h01) begin
                            state_ff <= rpd_pkg::RPD_IDLE;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                default: state_ff <= rpd_pkg::RPD_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // per-position peak and tag capture
    // ------------------------------------------------------------
    logic [AW-1:0] amp_a_ff;
    logic [AW-1:0] amp_b_ff;
    logic          main_a_ff;
    logic          main_b_ff;
    logic          sig_a_ff;
    logic          sig_b_ff;
    logic          in_b;

    assign in_b = cnt_ff >= CW'(rpd_pkg::CHIP_CYC);

    // peak over each half so a timing skew of a sample costs nothing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            amp_a_ff  <= '0;
            amp_b_ff  <= '0;
            main_a_ff <= 1'b0;
            main_b_ff <= 1'b0;
            sig_a_ff  <= 1'b0;
            sig_b_ff  <= 1'b0;
        end else if (state_ff != rpd_pkg::RPD_BITS || bit_end) begin
            amp_a_ff  <= '0;
            amp_b_ff  <= '0;
            main_a_ff <= 1'b0;
            main_b_ff <= 1'b0;
            sig_a_ff  <= 1'b0;
            sig_b_ff  <= 1'b0;
        end else if (!in_b) begin
            if (amp > amp_a_ff) begin
                amp_a_ff <= amp;
            end
            sig_a_ff  <= sig_a_ff | pulse;
            main_a_ff <= main_a_ff | (pulse & main);
        end else begin
            if (amp > amp_b_ff) begin
                amp_b_ff <= amp;
            end
            sig_b_ff  <= sig_b_ff | pulse;
            main_b_ff <= main_b_ff | (pulse & main);
        end
    end

    // ------------------------------------------------------------
    // bit decision
    // ------------------------------------------------------------
    logic a_wins;
    logic tie;
    logic conf;
    logic fa;
    logic fb;
    logic fma;
    logic fmb;
    logic [AW-1:0] pa;
    logic [AW-1:0] pb;

    // the last late-position sample lands with bit_end
    assign fa  = sig_a_ff;
    assign fb  = sig_b_ff | pulse;
    assign fma = main_a_ff;
    assign fmb = main_b_ff | (pulse & main);
    assign pa  = amp_a_ff;
    assign pb  = (amp > amp_b_ff) ? amp : amp_b_ff;

    always_comb begin
        a_wins = 1'b0;
        tie    = 1'b0;
        if (fa && fb && (fma != fmb)) begin
            a_wins = fma;
        end else if (pa > pb) begin
            a_wins = 1'b1;
        end else if (pa == pb) begin
            tie = 1'b1;
        end
    end

    // one mainlobe, other empty or sidelobe
    assign conf = !tie && ((fma && !fmb && !(fb && fmb)) || (fmb && !fma))
               && !(fma && fmb);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bit_vld_ff  <= 1'b0;
            bit_val_ff  <= 1'b0;
            bit_conf_ff <= 1'b0;
        end else begin
            bit_vld_ff <= (state_ff == rpd_pkg::RPD_BITS) && bit_end;
            if ((state_ff == rpd_pkg::RPD_BITS) && bit_end) begin
                bit_val_ff  <= tie ? TIE_BIT : (a_wins ? EARLY_IS : !EARLY_IS);
                bit_conf_ff <= conf;
            end
        end
    end

    // ------------------------------------------------------------
    // reply report
    // ------------------------------------------------------------
    // range and azimuth per reply
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reply_ff     <= 1'b0;
            reply_rc_ff  <= 1'b0;
            reply_toa_ff <= '0;
            reply_az_ff  <= '0;
        end else begin
            reply_ff <= accept;
            if (accept) begin
                reply_rc_ff  <= rc_arm;
                reply_toa_ff <= toa;
                reply_az_ff  <= angle;
            end
        end
    end

    // missed preambles: seen while busy or out of window
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lost_ff     <= 16'h0000;
            accepted_ff <= 16'h0000;
        end else begin
            if (enable_ff && lead_edge && !accept) begin
                lost_ff <= lost_ff + 16'h0001;
            end
            if (accept) begin
                accepted_ff <= accepted_ff + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd) begin
            unique case (addr)
                rpd_pkg::REG_CTRL:   rdata_ff <= {31'h0, enable_ff};
                rpd_pkg::REG_THRESH: rdata_ff <= 32'(thresh_ff);
                rpd_pkg::REG_STATUS: rdata_ff <= {accepted_ff, lost_ff[14:0], busy};
                rpd_pkg::REG_TOA:    rdata_ff <= 32'(reply_toa_ff);
                rpd_pkg::REG_AZ:     rdata_ff <= {15'h0, reply_rc_ff, 16'(reply_az_ff)};
                rpd_pkg::REG_NBITS:  rdata_ff <= {24'h0, nbits_ff};
                rpd_pkg::REG_DETECT: rdata_ff <= 32'(detect_ff);
                default:             rdata_ff <= 32'h0000_0000;
            endcase
        end
    end
endmodule // rpd_demod

/* File: rtl/rpd_pkg.sv */
// constants and types of the reply preamble bit demodulator
package rpd_pkg;
    // ------------------------------------------------------------
    // timing, in samples of the 10 MHz clock
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 10;
    localparam int CHIP_NS        = 500;
    localparam int CHIP_CYC       = (CHIP_NS * CLK_MHZ + 999) / 1000;
    // preamble pulse positions in chips from the first pulse
    localparam int PRE_P2_CHIP    = 2;
    localparam int PRE_P3_CHIP    = 7;
    localparam int PRE_P4_CHIP    = 9;
    localparam int PRE_LEN_CHIP   = 16;
    localparam int PRE_SPAN_CYC   = PRE_P4_CHIP * CHIP_CYC;
    localparam int DATA_OFS_CYC   = PRE_LEN_CHIP * CHIP_CYC;
    localparam int BIT_CYC        = 2 * CHIP_CYC;
    // ------------------------------------------------------------
    // register map (word index)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_THRESH  = 4'h1;
    localparam logic [3:0] REG_STATUS  = 4'h2;
    localparam logic [3:0] REG_TOA     = 4'h3;
    localparam logic [3:0] REG_AZ      = 4'h4;
    localparam logic [3:0] REG_CAL     = 4'h5;
    localparam logic [3:0] REG_NBITS   = 4'h6;
    localparam logic [3:0] REG_DETECT  = 4'h7;
    localparam int CTRL_EN_BIT         = 0;
    localparam logic [7:0]  THRESH_RST = 8'h0C;
    localparam logic [7:0]  DETECT_RST = 8'h20;
    localparam logic [7:0]  NBITS_RST  = 8'h38;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0001;

    typedef enum logic [1:0] {
        RPD_IDLE = 2'b00,
        RPD_WAIT = 2'b01,
        RPD_BITS = 2'b10
    } rpd_state_e;
endpackage : rpd_pkg

/* File: rtl/rpd_pulse_tag.sv */
// per-sample pulse detect and mainlobe tag
`timescale 1ns/10ps
module rpd_pulse_tag #(
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [AW-1:0] log_sum,
    input  wire logic [AW-1:0] log_omni,
    input  wire logic [AW-1:0] thresh,
    input  wire logic [AW-1:0] detect_lvl,
    output logic               pulse_ff,
    output logic               main_ff,
    output logic [AW-1:0]      amp_ff
);
    logic [AW:0] omni_plus;

    assign omni_plus = {1'b0, log_omni} + {1'b0, thresh};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_ff <= 1'b0;
            amp_ff   <= '0;
        end else begin
            pulse_ff <= log_sum > detect_lvl;
            amp_ff   <= (log_sum > detect_lvl) ? log_sum : '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            main_ff <= 1'b0;
        end else begin
            main_ff <= (log_sum > detect_lvl) && ({1'b0, log_sum} > omni_plus);
        end
    end
endmodule // rpd_pulse_tag

/* File: verification/rpd_demod_monitor.sv */
// concurrent checks on the demodulator ports
`timescale 1ns/10ps
module rpd_demod_monitor #(
    parameter int AW = 8,
    parameter int MW = 6,
    parameter int DW = 12,
    parameter int TW = 24
) (
    input wire logic          clk,
    input wire logic          rstn,
    input wire logic [AW-1:0] log_sum,
    input wire logic [AW-1:0] log_omni,
    input wire logic [MW-1:0] mono_ratio,
    input wire logic [TW-1:0] tod,
    input wire logic          rc_arm,
    input wire logic [TW-1:0] rc_expect,
    input wire logic [TW-1:0] rc_window,
    input wire logic [3:0]    addr,
    input wire logic [31:0]   wdata,
    input wire logic          wr,
    input wire logic          rd,
    input wire logic [31:0]   rdata_ff,
    input wire logic          reply_ff,
    input wire logic          reply_rc_ff,
    input wire logic [TW-1:0] reply_toa_ff,
    input wire logic [DW-1:0] reply_az_ff,
    input wire logic          bit_vld_ff,
    input wire logic          bit_val_ff,
    input wire logic          bit_conf_ff,
    input wire logic          busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [TW-1:0] toa_ref;
    logic [TW-1:0] toa_gap;
    // arrival time is taken one preamble span back from the decision
    assign toa_ref = tod - TW'(rpd_pkg::PRE_SPAN_CYC);
    assign toa_gap = (reply_toa_ff >= rc_expect) ? reply_toa_ff - rc_expect
                                                  : rc_expect - reply_toa_ff;
    // ------------------------------------------------------------
    // reply acceptance
    // ------------------------------------------------------------
    property p_take_idle;   reply_ff |-> busy && !$past(busy); endproperty
    a_take_idle:   assert property (p_take_idle) else $error("reply taken while busy");
    property p_no_restart;  reply_ff |=> !reply_ff [*8]; endproperty
    a_no_restart:  assert property (p_no_restart) else $error("reply restarted");
    property p_toa;         reply_ff |-> reply_toa_ff == $past(toa_ref); endproperty
    a_toa:         assert property (p_toa) else $error("arrival time off");
    property p_window;      reply_ff && reply_rc_ff |-> toa_gap <= rc_window; endproperty
    a_window:      assert property (p_window) else $error("roll-call outside window");
    property p_kind;        reply_ff |-> reply_rc_ff == $past(rc_arm); endproperty
    a_kind:        assert property (p_kind) else $error("reply kind wrong");
    // ------------------------------------------------------------
    // bits and register port
    // ------------------------------------------------------------
    property p_first_bit;   reply_ff |-> ##[30:60] bit_vld_ff; endproperty
    a_first_bit:   assert property (p_first_bit) else $error("no first bit");
    property p_bit_gap;     bit_vld_ff |=> !bit_vld_ff [*8]; endproperty
    a_bit_gap:     assert property (p_bit_gap) else $error("bits too close");
    property p_bit_in;      bit_vld_ff |-> busy || $past(busy); endproperty
    a_bit_in:      assert property (p_bit_in) else $error("bit outside reply");
    property p_unmapped;    rd && addr[3] |=> rdata_ff == 32'h0; endproperty
    a_unmapped:    assert property (p_unmapped) else $error("unmapped read not zero"); // map
    property p_rd_hold;     !rd |=> $stable(rdata_ff); endproperty
    a_rd_hold:     assert property (p_rd_hold) else $error("read data moved"); // map
    c_all:  cover property (reply_ff && !reply_rc_ff);
    c_rc:   cover property (reply_ff && reply_rc_ff);
    c_high: cover property (bit_vld_ff && bit_conf_ff);
endmodule // rpd_demod_monitor

bind rpd_demod rpd_demod_monitor #(.AW(AW), .MW(MW), .DW(DW), .TW(TW)) mon_u (
    .clk, .rstn, .log_sum, .log_omni, .mono_ratio, .tod, .rc_arm, .rc_expect,
    .rc_window, .addr, .wdata, .wr, .rd, .rdata_ff, .reply_ff, .reply_rc_ff,
    .reply_toa_ff, .reply_az_ff, .bit_vld_ff, .bit_val_ff, .bit_conf_ff, .busy
);

/* File: verification/rpd_video_model.sv */
// receiver video and time-of-day source in front of the demodulator
`timescale 1ns/10ps
module rpd_video_model (
    input  wire logic   clk,
    output logic [7:0]  log_sum,
    output logic [7:0]  log_omni,
    output logic [5:0]  mono_ratio,
    output logic [23:0] tod
);
    localparam logic [5:0] CAL_IDX = 6'h05;
    initial begin
        log_sum    = 8'h00;
        log_omni   = 8'h00;
        mono_ratio = ~CAL_IDX;
        tod        = 24'h001000;
    end
    always @(posedge clk) tod <= tod + 24'h000001;
    task automatic put(input logic [15:0] so, input logic [5:0] r);
        @(posedge clk);
        log_sum    <= so[15:8];
        log_omni   <= so[7:0];
        mono_ratio <= r;
    endtask
    // each bit word is {early sum, early omni, late sum, late omni}
    task automatic send(input logic [31:0] b [6]);
        int i;
        int j;
        for (i = 0; i < 80; i++) begin
            if (i == 0 || i == 10 || i == 35 || i == 45) put(16'h6010, CAL_IDX);
            // ratio is only meaningful around the last pulse
            else put(16'h0000, (i > 42 && i < 48) ? CAL_IDX : ~CAL_IDX);
        end
        for (i = 0; i < 6; i++) begin
            for (j = 0; j < 10; j++) put((j < 5) ? b[i][31:16] : b[i][15:0], ~CAL_IDX);
        end
        put(16'h0000, ~CAL_IDX);
    endtask
endmodule // rpd_video_model

/* File: verification/tb_reply_preamble_bit_demodulator.sv */
// self-checking bench of the reply demodulator
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_reply_preamble_bit_demodulator;
    // mainlobe 60/10, sidelobe same sum and omni, tie, mixed
    localparam logic [31:0] BITS [6] = '{32'h6010_0000, 32'h0000_6010, 32'h6010_6010,
                                         32'h7070_5010, 32'h7070_5050, 32'h6060_0000};
    localparam logic [1:0]  EXP [6]  = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
    logic        clk, rstn, rc_arm, wr, rd;
    logic [7:0]  log_sum, log_omni;
    logic [5:0]  mono_ratio;
    logic [23:0] tod, rc_expect, rc_window, reply_toa_ff, toa_seen;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata_ff;
    logic        reply_ff, reply_rc_ff, bit_vld_ff, bit_val_ff, bit_conf_ff, busy, rc_seen;
    logic [11:0] reply_az_ff, az_seen;
    logic [1:0]  bits_q [$];
    int          n_tests, fails, n_rep;

    rpd_video_model prt_u (.clk, .log_sum, .log_omni, .mono_ratio, .tod);
    rpd_demod dut_u (
        .clk, .rstn, .log_sum, .log_omni, .mono_ratio, .tod, .rc_arm, .rc_expect,
        .rc_window, .addr, .wdata, .wr, .rd, .rdata_ff, .reply_ff, .reply_rc_ff,
        .reply_toa_ff, .reply_az_ff, .bit_vld_ff, .bit_val_ff, .bit_conf_ff, .busy
    );
    always #50 clk = ~clk;
    // outputs seen here are those of the cycle just ended
    always @(posedge clk) begin
        if (bit_vld_ff === 1'b1) bits_q.push_back({bit_val_ff, bit_conf_ff});
        if (reply_ff === 1'b1) begin
            n_rep++;
            toa_seen = reply_toa_ff;
            az_seen  = reply_az_ff;
            rc_seen  = reply_rc_ff;
        end
    end
    // ------------------------------------------------------------
    // register port and reply tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK("rdata", e, rdata_ff)
    endtask
    // ofs puts the expected time far off unless zero
    task automatic run_reply(input logic arm, input logic [23:0] ofs, input logic acc);
        logic [23:0] t0;
        int          n0;
        int          k;
        n0 = n_rep;
        bits_q.delete();
        @(posedge clk);
        t0 = prt_u.tod + 24'h000002;
        rc_arm    <= arm;
        rc_expect <= t0 + ofs;
        prt_u.send(BITS);
        for (k = 0; k < 60 && busy !== 1'b0; k++) begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'b0) begin
            fails++;
            conclude();
        end
        // let the sampler take the last bit
        @(posedge clk);
        #1;
        `CHK("reply", acc, n_rep == n0 + 1)
        if (acc) begin
            // pulse register and history lag two samples
            `CHK("toa", t0 + 24'h000002, toa_seen)
            `CHK("az", 12'hABC, az_seen)
            `CHK("kind", arm, rc_seen)
            `CHK("nbits", 6, bits_q.size())
            for (k = 0; k < 6; k++) `CHK("bit", EXP[k], bits_q[k])
        end
    endtask
    initial begin
        clk       = 1'b0;
        rstn      = 1'b0;
        rc_arm    = 1'b0;
        rc_expect = 24'h000000;
        rc_window = 24'h000002;
        addr      = 4'h0;
        wdata     = 32'h0;
        wr        = 1'b0;
        rd        = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(rpd_pkg::REG_CTRL, 32'h1);
        rd_reg(rpd_pkg::REG_THRESH, 32'hC);
        rd_reg(rpd_pkg::REG_DETECT, 32'h20);
        rd_reg(rpd_pkg::REG_NBITS, 32'h38);
        rd_reg(rpd_pkg::REG_STATUS, 32'h0);
        rd_reg(4'hF, 32'h0);
        wr_reg(rpd_pkg::REG_STATUS, 32'hFFFF_FFFF);
        wr_reg(rpd_pkg::REG_NBITS, 32'h6);
        wr_reg(rpd_pkg::REG_CAL, 32'h0005_0ABC);
        rd_reg(rpd_pkg::REG_CAL, 32'h0);
        rd_reg(rpd_pkg::REG_NBITS, 32'h6);
        run_reply(1'b0, 24'h000064, 1'b1);
        run_reply(1'b1, 24'h000000, 1'b1);
        run_reply(1'b1, 24'h000064, 1'b0);
        rd_reg(rpd_pkg::REG_STATUS, 32'h0002_0002);
        conclude();
    end
endmodule // tb_reply_preamble_bit_demodulator
